/* File: hot_swap_on_off_sequencer.sv */
/*
 Turn-on/turn-off sequencer of a hot swap controller: lockouts, power-on
 reset, debounce, power good chain, watchdog, fault responses, registers.
 Assumes comparator outputs arrive asynchronously and a nonvolatile copy of
 each control register is presented at its nv port.
*/
//
// Function
// - After both supply lockouts clear, hold power-on reset for 1.3ms.
// - Window good and insert low for 128ms; any violation restarts debounce.
// - After debounce, turn on when on-request bit is, or becomes, one.
// - Set switch_commanded_on_flag while the switch is commanded on.
// - Set gate_enhanced_flag while gate is above supply minus 1.8V.
// - During power-on reset clear faults and load controls from nonvolatile copies.
// - Clear power_on_reset_sticky on internal supply low; software sets it.
// - Slew mode enables ramp source past gate threshold; else current-limit inrush.
// - Slew control only at startup; discharge ramp on power good or turn-off.
// - Startup foldback selectable among four ratios, flat during startup.
// - Drain low, output high, gate high after turn-on latch power good.
// - good_output_one after 256ms, good_output_two after further 256ms.
// - Then 512ms watchdog; inactive good_check_input turns off, logs fault.
// - With good_check_retry_en, retry 128ms after good-check fault, else stay off.
// - Good pin polarities configurable; general purpose mode disables the watchdog.
// - Power good resets on output low with CP_PGRST_BIT set, else on non-overvoltage turn-off.
// - Resetting power good also resets both good delays and the watchdog.
// - Any turn-off cause pulls the gate down and clears the on flag.
// - Undervoltage needs both senses low; overvoltage on surge sense high.
// - Switch-bad after configured delay; switch and external turn-off are enable-gated.
// - Restart request turns off then restarts; per-fault latch-off or retry.
`include "hot_swap_regs.svh"

module hot_swap_on_off_sequencer import hot_swap_pkg::*; #(
	parameter int TICK_CYCLES = `TICK_CYCLES,
	parameter int POR_TICKS = `POR_TIME_US * `TICKS_PER_US,
	parameter int DEBOUNCE_TICKS = `DEBOUNCE_TIME_US * `TICKS_PER_US,
	parameter int GOOD_TICKS = `GOOD_DELAY_TIME_US * `TICKS_PER_US,
	parameter int WATCHDOG_TICKS = `WATCHDOG_TIME_US * `TICKS_PER_US,
	parameter int RETRY_TICKS = `RETRY_TIME_US * `TICKS_PER_US,
	parameter int SWBAD_UNIT_TICKS = `SWBAD_UNIT_US * `TICKS_PER_US,
	parameter int RESTART_UNIT_TICKS = `RESTART_UNIT_US * `TICKS_PER_US
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic chip_supply_on_i,
	input wire logic chip_supply_low_i,
	input wire logic internal_supply_on_i,
	input wire logic internal_supply_low_i,
	input wire logic undervoltage_rising_sense_i,
	input wire logic undervoltage_falling_sense_i,
	input wire logic input_surge_sense_i,
	input wire logic insert_detect_n_i,
	input wire logic thermal_timer_node_i,
	input wire logic drain_sense_i,
	input wire logic gate_high_i,
	input wire logic gate_threshold_i,
	input wire logic output_good_threshold_i,
	input wire logic good_check_input_i,
	input wire logic external_fault_pin_i,
	input wire logic [7:0] nv_control_primary_i,
	input wire logic [7:0] nv_control_secondary_i,
	input wire logic [7:0] nv_threshold_reset_i,
	input wire logic [7:0] nv_fault_response_i,
	input wire logic [7:0] nv_good_polarity_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic gate_on_o,
	output logic ramp_source_en_o,
	output logic ramp_discharge_o,
	output logic slew_mode_o,
	output logic [1:0] foldback_sel_o,
	output logic good_output_one_o,
	output logic good_output_two_o
);
	localparam int TW = 20;
	localparam int PW = 9;

	////////////////////////////////////////////////////////////////////////////////
	// Reset release and input synchronisers
	logic rst_meta, rst_n;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	cmp_t raw, s1, s2, s3, cmp;
	assign raw = {chip_supply_on_i, chip_supply_low_i, internal_supply_on_i,
		internal_supply_low_i, undervoltage_rising_sense_i, undervoltage_falling_sense_i,
		input_surge_sense_i, insert_detect_n_i, thermal_timer_node_i, drain_sense_i,
		gate_high_i, gate_threshold_i, output_good_threshold_i, good_check_input_i,
		external_fault_pin_i};
	// Filtered copy moves only when stages two and three agree
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			cmp <= '0;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			cmp <= ((s2 ~^ s3) & s3) | ((s2 ^ s3) & cmp);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Timebase
	logic [PW-1:0] prescale;
	logic tick;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			prescale <= '0;
			tick <= 1'b0;
		end else begin
			tick <= prescale == PW'(TICK_CYCLES - 1);
			prescale <= (prescale == PW'(TICK_CYCLES - 1)) ? '0 : prescale + 1'b1;
		end
	end

	timer_if #(.W(TW)) seq_t();
	timer_if #(.W(TW)) chain_t_if();
	timer_if #(.W(TW)) swbad_t();
	seq_timer #(.W(TW)) u_seq(.clk_i(clk_i), .rst_n_i(rst_n), .tick_i(tick), .t(seq_t));
	seq_timer #(.W(TW)) u_chain(.clk_i(clk_i), .rst_n_i(rst_n), .tick_i(tick), .t(chain_t_if));
	seq_timer #(.W(TW)) u_swbad(.clk_i(clk_i), .rst_n_i(rst_n), .tick_i(tick), .t(swbad_t));

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	state_t state, next_state;
	chain_t chain;
	logic pg, por_sticky;
	logic [7:0] ctrl1, ctrl2, thr_cfg, flt_cfg, pol_cfg, restart_reg, fault_log;
	logic [7:0] fault_set;
	logic restart_ack;
	logic [TW-1:0] retry_ticks, next_retry;

	wire in_por = state == ST_POR;
	wire wr_ctrl1 = reg_wr_i && reg_addr_i == `ADDR_CONTROL_PRIMARY;
	wire wr_ctrl2 = reg_wr_i && reg_addr_i == `ADDR_CONTROL_SECONDARY;
	wire wr_thr = reg_wr_i && reg_addr_i == `ADDR_THRESHOLD_RESET;
	wire wr_flt_cfg = reg_wr_i && reg_addr_i == `ADDR_FAULT_RESPONSE;
	wire wr_pol = reg_wr_i && reg_addr_i == `ADDR_GOOD_POLARITY;
	wire wr_restart = reg_wr_i && reg_addr_i == `ADDR_RESTART;
	wire wr_fault = reg_wr_i && reg_addr_i == `ADDR_FAULT_LOG;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1 <= 8'h00;
			ctrl2 <= 8'h00;
			thr_cfg <= 8'h00;
			flt_cfg <= 8'h00;
			pol_cfg <= 8'h00;
		end else if (in_por) begin
			ctrl1 <= nv_control_primary_i;
			ctrl2 <= nv_control_secondary_i;
			thr_cfg <= nv_threshold_reset_i;
			flt_cfg <= nv_fault_response_i;
			pol_cfg <= nv_good_polarity_i;
		end else begin
			if (wr_ctrl1) ctrl1 <= reg_wdata_i;
			if (wr_ctrl2) ctrl2 <= reg_wdata_i;
			if (wr_thr) thr_cfg <= reg_wdata_i;
			if (wr_flt_cfg) flt_cfg <= reg_wdata_i;
			if (wr_pol) pol_cfg <= reg_wdata_i;
		end
	end

	// Hardware set wins over a software write in the same cycle
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fault_log <= 8'h00;
			restart_reg <= 8'h00;
			por_sticky <= 1'b0;
		end else begin
			if (in_por) fault_log <= 8'h00;
			else fault_log <= ((wr_fault ? reg_wdata_i : fault_log) | fault_set) & `FLT_MASK;
			if (wr_restart) restart_reg <= reg_wdata_i;
			else if (restart_ack) restart_reg[`RS_REQ_BIT] <= 1'b0;
			if (cmp.int_low) por_sticky <= 1'b0;
			else if (wr_thr) por_sticky <= reg_wdata_i[`TR_STICKY_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Turn-on / turn-off state machine
	wire on_request = ctrl1[`CP_ON_BIT];
	wire supply_low = cmp.chip_low || cmp.int_low || !cmp.chip_on || !cmp.int_on;
	wire window_ok = cmp.uvh_above && cmp.uvl_above && !cmp.ov_above && !cmp.insert_n;
	wire gc_active = pol_cfg[`GP_GC_POL_BIT] ? cmp.gc_pin : !cmp.gc_pin;
	wire ext_active = flt_cfg[`FR_EXT_POL_BIT] ? cmp.ext_pin : !cmp.ext_pin;
	wire f_ov = cmp.ov_above;
	wire f_uv = !cmp.uvl_above && !cmp.uvh_above;
	wire f_oc = cmp.thermal_trip;
	wire swbad_cond = pg && (cmp.drain_high || !cmp.gate_high);
	wire swbad_evt = swbad_t.expired && swbad_cond;
	wire f_sb = swbad_evt && ctrl1[`CP_SWBAD_EN_BIT];
	wire gc_evt = chain == CH_WD && chain_t_if.expired && !gc_active;
	wire f_ext = ext_active && flt_cfg[`FR_EXT_EN_BIT];
	wire hard_off = !on_request || cmp.insert_n;
	wire any_fault = f_ov || f_uv || f_oc || f_sb || gc_evt || f_ext;
	// Retry only when every active fault allows it
	wire all_retry = (!f_ov || ctrl2[`CS_OV_RETRY_BIT]) && (!f_uv || ctrl2[`CS_UV_RETRY_BIT]) &&
		(!f_oc || ctrl2[`CS_OC_RETRY_BIT]) && (!f_sb || ctrl2[`CS_SWBAD_RETRY_BIT]) &&
		(!gc_evt || ctrl2[`CS_GC_RETRY_BIT]) && (!f_ext || ctrl2[`CS_EXT_RETRY_BIT]);
	wire on_now = state == ST_ON;

	assign fault_set = on_now ? {2'b00, ext_active, gc_evt, swbad_evt, f_oc, f_uv, f_ov} : 8'h00;

	always_comb begin
		next_state = state;
		next_retry = retry_ticks;
		restart_ack = 1'b0;
		if (supply_low) begin
			next_state = ST_OFF;
		end else begin
			case (state)
				ST_OFF: if (cmp.chip_on && cmp.int_on) next_state = ST_POR;
				ST_POR: if (seq_t.expired) next_state = ST_DEBOUNCE;
				ST_DEBOUNCE: if (seq_t.expired && window_ok) next_state = ST_WAIT_ON;
				ST_WAIT_ON: begin
					if (!window_ok) next_state = ST_DEBOUNCE;
					else if (on_request) next_state = ST_ON;
				end
				ST_ON: begin
					if (hard_off) begin
						next_state = ST_DEBOUNCE;
					end else if (any_fault) begin
						next_state = all_retry ? ST_RETRY : ST_LATCHED;
						next_retry = TW'(RETRY_TICKS);
					end else if (restart_reg[`RS_REQ_BIT]) begin
						next_state = ST_RETRY;
						restart_ack = 1'b1;
						next_retry = TW'(RESTART_UNIT_TICKS * (int'(restart_reg[`RS_DLY_MSB:`RS_DLY_LSB]) + 1));
					end
				end
				ST_RETRY: if (seq_t.expired) next_state = ST_WAIT_ON;
				ST_LATCHED: if (!on_request) next_state = ST_DEBOUNCE;
				default: next_state = ST_OFF;
			endcase
		end
	end

	assign seq_t.start = (next_state != state) || (state == ST_DEBOUNCE && !window_ok);
	assign seq_t.stop = 1'b0;
	assign seq_t.count = (next_state == ST_POR) ? TW'(POR_TICKS) :
		(next_state == ST_RETRY) ? next_retry : TW'(DEBOUNCE_TICKS);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_OFF;
			retry_ticks <= '0;
		end else begin
			state <= next_state;
			retry_ticks <= next_retry;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power good and delay chain
	wire gate_off_evt = on_now && next_state != ST_ON;
	wire off_by_ov = f_ov && !hard_off && !supply_low;
	wire pg_set = on_now && !pg && !cmp.drain_high && cmp.output_high && cmp.gate_high;
	wire pg_reset = pg && (ctrl1[`CP_PGRST_BIT] ? !cmp.output_high : (gate_off_evt && !off_by_ov));
	wire gc_gpio = pol_cfg[`GP_GC_GPIO_BIT];
	chain_t next_chain;

	always_comb begin
		next_chain = chain;
		if (pg_reset || in_por) next_chain = CH_IDLE;
		else if (pg_set) next_chain = CH_D1;
		else if (chain_t_if.expired) begin
			case (chain)
				CH_D1: next_chain = CH_D2;
				CH_D2: next_chain = gc_gpio ? CH_DONE : CH_WD;
				CH_WD: next_chain = CH_DONE;
				default: next_chain = chain;
			endcase
		end
	end

	assign chain_t_if.start = next_chain != chain && next_chain != CH_IDLE && next_chain != CH_DONE;
	assign chain_t_if.stop = next_chain == CH_IDLE || next_chain == CH_DONE;
	assign chain_t_if.count = (next_chain == CH_WD) ? TW'(WATCHDOG_TICKS) : TW'(GOOD_TICKS);

	logic swbad_t_armed;
	assign swbad_t.start = swbad_cond && !swbad_t.expired && swbad_t.stop == 1'b0 &&
		!(swbad_t_armed);
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) swbad_t_armed <= 1'b0;
		else swbad_t_armed <= swbad_cond;
	end
	assign swbad_t.stop = !swbad_cond;
	assign swbad_t.count = TW'(SWBAD_UNIT_TICKS * (int'(thr_cfg[`TR_SWBAD_DLY_MSB:`TR_SWBAD_DLY_LSB]) + 1));

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pg <= 1'b0;
			chain <= CH_IDLE;
		end else begin
			if (in_por || pg_reset) pg <= 1'b0;
			else if (pg_set) pg <= 1'b1;
			chain <= next_chain;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs and read port
	wire good1 = chain == CH_D2 || chain == CH_WD || chain == CH_DONE;
	wire good2 = chain == CH_WD || chain == CH_DONE;
	wire slew_sel = ctrl1[`CP_SLEW_BIT];
	// Slew control stops at power good so a later current-limit event is not masked
	wire slew_active = slew_sel && on_now && !pg;
	wire [7:0] sys_flags = {3'b000, good2, good1, pg, cmp.gate_high, on_now};
	wire [7:0] thr_read = {thr_cfg[7:1], por_sticky};
	wire [7:0] rd_mux = (reg_addr_i == `ADDR_SYSTEM_STATE) ? sys_flags :
		(reg_addr_i == `ADDR_FAULT_LOG) ? fault_log :
		(reg_addr_i == `ADDR_CONTROL_PRIMARY) ? ctrl1 :
		(reg_addr_i == `ADDR_CONTROL_SECONDARY) ? ctrl2 :
		(reg_addr_i == `ADDR_THRESHOLD_RESET) ? thr_read :
		(reg_addr_i == `ADDR_FAULT_RESPONSE) ? flt_cfg :
		(reg_addr_i == `ADDR_GOOD_POLARITY) ? pol_cfg :
		(reg_addr_i == `ADDR_RESTART) ? restart_reg : 8'h00;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o <= 8'h00;
			gate_on_o <= 1'b0;
			ramp_source_en_o <= 1'b0;
			ramp_discharge_o <= 1'b1;
			slew_mode_o <= 1'b0;
			foldback_sel_o <= 2'b00;
			good_output_one_o <= 1'b0;
			good_output_two_o <= 1'b0;
		end else begin
			if (reg_rd_i) reg_rdata_o <= rd_mux;
			gate_on_o <= next_state == ST_ON;
			ramp_source_en_o <= slew_active && cmp.gate_thresh;
			ramp_discharge_o <= !slew_active;
			slew_mode_o <= slew_sel;
			foldback_sel_o <= ctrl1[`CP_FB_MSB:`CP_FB_LSB];
			good_output_one_o <= good1 ^ pol_cfg[`GP_INV1_BIT];
			good_output_two_o <= good2 ^ pol_cfg[`GP_INV2_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_por_hold;
		@(posedge clk_i) disable iff (!rst_n)
		state == ST_OFF && !(cmp.chip_on && cmp.int_on) |=> state == ST_OFF;
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("left off without lockouts");

	property p_debounce_restart;
		@(posedge clk_i) disable iff (!rst_n)
		state == ST_DEBOUNCE && !window_ok && !supply_low |=> state == ST_DEBOUNCE && !seq_t.expired;
	endproperty
	a_debounce_restart: assert property (p_debounce_restart) else $error("debounce kept");

	property p_turn_on;
		@(posedge clk_i) disable iff (!rst_n)
		state == ST_WAIT_ON && window_ok && on_request && !supply_low |=> on_now && gate_on_o;
	endproperty
	a_turn_on: assert property (p_turn_on) else $error("no turn on");

	property p_on_flag;
		@(posedge clk_i) disable iff (!rst_n)
		$rose(on_now) |-> sys_flags[`SYS_ON_BIT] && $past(state) == ST_WAIT_ON;
	endproperty
	a_on_flag: assert property (p_on_flag) else $error("on flag wrong");

	property p_por_clear;
		@(posedge clk_i) disable iff (!rst_n)
		in_por |=> fault_log == 8'h00 && ctrl1 == $past(nv_control_primary_i);
	endproperty
	a_por_clear: assert property (p_por_clear) else $error("por load failed");

	property p_sticky;
		@(posedge clk_i) disable iff (!rst_n)
		cmp.int_low |=> !por_sticky ##0 !thr_read[`TR_STICKY_BIT];
	endproperty
	a_sticky: assert property (p_sticky) else $error("sticky not cleared");

	property p_ramp_off;
		@(posedge clk_i) disable iff (!rst_n)
		pg |=> ramp_discharge_o && !ramp_source_en_o;
	endproperty
	a_ramp_off: assert property (p_ramp_off) else $error("ramp active at power good");

	property p_pg_latch;
		@(posedge clk_i) disable iff (!rst_n)
		pg_set && !pg_reset |=> pg && chain == CH_D1 ##1 !good1;
	endproperty
	a_pg_latch: assert property (p_pg_latch) else $error("power good not latched");

	property p_gc_fault;
		@(posedge clk_i) disable iff (!rst_n)
		gc_evt && on_now && !supply_low && !hard_off |=>
			!on_now && fault_log[`FLT_GC_BIT] ##1 !gate_on_o;
	endproperty
	a_gc_fault: assert property (p_gc_fault) else $error("good check fault missed");

	property p_pg_chain_reset;
		@(posedge clk_i) disable iff (!rst_n)
		pg_reset |=> chain == CH_IDLE && !pg;
	endproperty
	a_pg_chain_reset: assert property (p_pg_chain_reset) else $error("chain not reset");

	property p_insert_off;
		@(posedge clk_i) disable iff (!rst_n)
		on_now && cmp.insert_n |=> !on_now && !gate_on_o && !sys_flags[`SYS_ON_BIT];
	endproperty
	a_insert_off: assert property (p_insert_off) else $error("no turn off");

	c_on: cover property (@(posedge clk_i) disable iff (!rst_n) $rose(on_now));
	c_good2: cover property (@(posedge clk_i) disable iff (!rst_n) chain == CH_WD);
	c_retry: cover property (@(posedge clk_i) disable iff (!rst_n) state == ST_RETRY);
	c_latched: cover property (@(posedge clk_i) disable iff (!rst_n) state == ST_LATCHED);
endmodule

/* File: hot_swap_on_off_sequencer_tb_top.sv */
/*
 Self-checking bench of the hot swap sequencer.
 Assumes the pass switch model answers the gate command.
*/
module hot_swap_on_off_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// External fault pin idles high: its default polarity is active low
	logic clk = 1'b0, rst_n = 1'b0, ok = 1'b0, ov = 1'b0, tmr = 1'b0, ext = 1'b1;
	logic vin_on = 1'b0, vin_low = 1'b1, icc_on = 1'b0, icc_low = 1'b1;
	logic undervoltage_rising_sense = 1'b0, undervoltage_falling_sense = 1'b0, ins_n = 1'b1;
	logic wr = 1'b0, rd = 1'b0, thr, ghi, drn, outg, gc, gon, g1, g2, rdis, rsrc, slw;
	logic [1:0] fb;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdat, nvp = 8'h21, nvt = 8'h00, nvg = 8'h04;
	logic [3:0] mon;
	int err_count = 0, cmp_count = 0, cyc = 0, c0;
	assign mon = {rsrc, g2, g1, gon};
	initial forever #2 clk = ~clk;
	always @(posedge clk) cyc++;
	// Short counts keep the whole run to a few thousand cycles
	hot_swap_on_off_sequencer #(.TICK_CYCLES(4), .POR_TICKS(4), .DEBOUNCE_TICKS(8),
		.GOOD_TICKS(8), .WATCHDOG_TICKS(8), .RETRY_TICKS(8), .SWBAD_UNIT_TICKS(4),
		.RESTART_UNIT_TICKS(4)) u_hot_swap_on_off_sequencer (.clk_i(clk), .rst_n_i(rst_n),
		.chip_supply_on_i(vin_on), .chip_supply_low_i(vin_low),
		.internal_supply_on_i(icc_on), .internal_supply_low_i(icc_low),
		.undervoltage_rising_sense_i(undervoltage_rising_sense), .undervoltage_falling_sense_i(undervoltage_falling_sense),
		.input_surge_sense_i(ov), .insert_detect_n_i(ins_n),
		.thermal_timer_node_i(tmr), .drain_sense_i(drn),
		.gate_high_i(ghi), .gate_threshold_i(thr), .output_good_threshold_i(outg),
		.good_check_input_i(gc), .external_fault_pin_i(ext), .nv_control_primary_i(nvp),
		.nv_control_secondary_i(8'h00), .nv_threshold_reset_i(nvt),
		.nv_fault_response_i(8'h00), .nv_good_polarity_i(nvg), .reg_addr_i(addr),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat), .gate_on_o(gon),
		.ramp_source_en_o(rsrc), .ramp_discharge_o(rdis), .slew_mode_o(slw),
		.foldback_sel_o(fb), .good_output_one_o(g1), .good_output_two_o(g2));
	pass_switch_model u_pass_switch_model (.clk_i(clk), .gate_on_i(gon), .monitor_ok_i(ok),
		.gate_threshold_o(thr), .gate_high_o(ghi), .drain_sense_o(drn),
		.output_good_o(outg), .good_check_o(gc));
	////////////////////////////////////////////////////////////////////////////////
	task conclude();
		if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [7:0] g, e);
		cmp_count++;
		if (g !== e) begin
			$display("BAD %0t got %h want %h", $time, g, e);
			err_count++;
		end
	endtask
	task wt(input int b, input logic v);
		int n;
		n = 0;
		while (mon[b] !== v && n < 3000) begin
			@(negedge clk);
			n++;
		end
		if (n == 3000) begin
			$display("BAD %0t wait %0d timed out", $time, b);
			err_count++;
			conclude();
		end
	endtask
	task wr_reg(input logic [7:0] a, d);
		@(negedge clk);
		addr = a;
		wd = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	// Data is taken one edge after the read, so wait a full cycle
	task rdr(input logic [7:0] a, m, e);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		@(negedge clk);
		chk(rdat & m, e);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		vin_on = 1'b1;
		vin_low = 1'b0;
		icc_on = 1'b1;
		icc_low = 1'b0;
		undervoltage_rising_sense = 1'b1;
		undervoltage_falling_sense = 1'b1;
		ins_n = 1'b0;
		c0 = cyc;
		wt(0, 1'b1);
		chk(8'(cyc - c0 >= 48), 8'h01);
		chk({slw, 5'h00, fb}, 8'h02);
		rdr(8'h0a, 8'hff, 8'h21);
		rdr(8'h04, 8'hff, 8'h00);
		wt(1, 1'b1);
		c0 = cyc;
		chk({7'h00, rdis}, 8'h01);
		wt(2, 1'b1);
		chk(8'(cyc - c0 inside {[28:36]}), 8'h01);
		rdr(8'h00, 8'h1f, 8'h1f);
		wt(0, 1'b0);
		repeat (2) @(negedge clk);
		chk({6'h00, g2, g1}, 8'h00);
		rdr(8'h04, 8'h10, 8'h10);
		repeat (200) @(negedge clk);
		chk({7'h00, gon}, 8'h00);
		ok = 1'b1;
		wr_reg(8'h0a, 8'h20);
		wr_reg(8'h0a, 8'h21);
		wt(2, 1'b1);
		repeat (100) @(negedge clk);
		chk({7'h00, gon}, 8'h01);
		wr_reg(8'h0a, 8'h20);
		wt(0, 1'b0);
		rdr(8'h00, 8'h01, 8'h00);
		wr_reg(8'h0e, 8'h01);
		rdr(8'h0e, 8'h01, 8'h01);
		icc_low = 1'b1;
		repeat (10) @(negedge clk);
		icc_low = 1'b0;
		rdr(8'h0e, 8'h01, 8'h00);
		wt(0, 1'b1);
		wr_reg(8'ha2, 8'h01);
		wt(0, 1'b0);
		c0 = cyc;
		rdr(8'ha2, 8'h01, 8'h00);
		wt(0, 1'b1);
		chk(8'(cyc - c0 inside {[12:24]}), 8'h01);
		wr_reg(8'h0f, 8'h01);
		wr_reg(8'h0b, 8'h20);
		ext = 1'b0;
		wt(0, 1'b0);
		rdr(8'h04, 8'h20, 8'h20);
		ext = 1'b1;
		wt(0, 1'b1);
		tmr = 1'b1;
		wt(0, 1'b0);
		rdr(8'h04, 8'h04, 8'h04);
		tmr = 1'b0;
		wr_reg(8'h0a, 8'h20);
		wr_reg(8'h0a, 8'h23);
		wt(3, 1'b1);
		chk({7'h00, rdis}, 8'h00);
		wt(1, 1'b1);
		chk({7'h00, rsrc}, 8'h00);
		ins_n = 1'b1;
		wt(0, 1'b0);
		ins_n = 1'b0;
		wt(0, 1'b1);
		undervoltage_falling_sense = 1'b0;
		repeat (10) @(negedge clk);
		chk({7'h00, gon}, 8'h01);
		undervoltage_rising_sense = 1'b0;
		wt(0, 1'b0);
		rdr(8'h04, 8'h02, 8'h02);
		undervoltage_rising_sense = 1'b1;
		undervoltage_falling_sense = 1'b1;
		wr_reg(8'h0a, 8'h20);
		wr_reg(8'h0a, 8'h23);
		wt(1, 1'b1);
		ov = 1'b1;
		wt(0, 1'b0);
		rdr(8'h00, 8'h05, 8'h04);
		rdr(8'h04, 8'h01, 8'h01);
		conclude();
	end
endmodule

/* File: hot_swap_pkg.sv */
/*
 Types of the hot swap on/off sequencer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package hot_swap_pkg;
	typedef enum logic [2:0] {ST_OFF, ST_POR, ST_DEBOUNCE, ST_WAIT_ON, ST_ON, ST_RETRY,
		ST_LATCHED} state_t;
	typedef enum logic [2:0] {CH_IDLE, CH_D1, CH_D2, CH_WD, CH_DONE} chain_t;
	typedef struct packed {
		logic chip_on;
		logic chip_low;
		logic int_on;
		logic int_low;
		logic uvh_above;
		logic uvl_above;
		logic ov_above;
		logic insert_n;
		logic thermal_trip;
		logic drain_high;
		logic gate_high;
		logic gate_thresh;
		logic output_high;
		logic gc_pin;
		logic ext_pin;
	} cmp_t;
endpackage

/* File: hot_swap_regs.svh */
/*
 Register offsets, field positions and timing figures of the
 hot swap on/off sequencer. Assumes inclusion by bare name from design files.
*/
`ifndef HOT_SWAP_REGS_SVH
`define HOT_SWAP_REGS_SVH

`define ADDR_SYSTEM_STATE 8'h00
`define ADDR_FAULT_LOG 8'h04
`define ADDR_CONTROL_PRIMARY 8'h0a
`define ADDR_CONTROL_SECONDARY 8'h0b
`define ADDR_THRESHOLD_RESET 8'h0e
`define ADDR_FAULT_RESPONSE 8'h0f
`define ADDR_GOOD_POLARITY 8'h10
`define ADDR_RESTART 8'ha2

// system_state_flags
`define SYS_ON_BIT 0
`define SYS_GATE_BIT 1
`define SYS_PG_BIT 2
`define SYS_GOOD1_BIT 3
`define SYS_GOOD2_BIT 4
// fault_log_flags
`define FLT_OV_BIT 0
`define FLT_UV_BIT 1
`define FLT_OC_BIT 2
`define FLT_SWBAD_BIT 3
`define FLT_GC_BIT 4
`define FLT_EXT_BIT 5
`define FLT_MASK 8'h3f
// switch_control_primary
`define CP_ON_BIT 0
`define CP_SLEW_BIT 1
`define CP_PGRST_BIT 2
`define CP_SWBAD_EN_BIT 3
`define CP_FB_LSB 4
`define CP_FB_MSB 5
// switch_control_secondary: per-fault retry enables
`define CS_GC_RETRY_BIT 0
`define CS_OV_RETRY_BIT 1
`define CS_UV_RETRY_BIT 2
`define CS_OC_RETRY_BIT 3
`define CS_SWBAD_RETRY_BIT 4
`define CS_EXT_RETRY_BIT 5
// threshold_and_reset_config
`define TR_STICKY_BIT 0
`define TR_SWBAD_DLY_LSB 4
`define TR_SWBAD_DLY_MSB 7
// fault_response_config
`define FR_EXT_EN_BIT 0
`define FR_EXT_POL_BIT 1
// good_pin_polarity_config
`define GP_INV1_BIT 0
`define GP_INV2_BIT 1
`define GP_GC_POL_BIT 2
`define GP_GC_GPIO_BIT 3
// restart_command
`define RS_REQ_BIT 0
`define RS_DLY_LSB 1
`define RS_DLY_MSB 3

// Timing
`define CLK_PERIOD_NS 4
`define TICK_PERIOD_NS 1000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define POR_TIME_US 1300
`define DEBOUNCE_TIME_US 128000
`define GOOD_DELAY_TIME_US 256000
`define WATCHDOG_TIME_US 512000
`define RETRY_TIME_US 128000
`define SWBAD_UNIT_US 1000
`define RESTART_UNIT_US 100000
`define TICKS_PER_US (1000 / `TICK_PERIOD_NS)

`endif

/* File: pass_switch_model.sv */
/*
 Pass switch, load and external supply monitor model.
 Assumes the gate command comes from the sequencer on the same clock.
*/
module pass_switch_model (
	input wire logic clk_i,
	input wire logic gate_on_i,
	input wire logic monitor_ok_i,
	output logic gate_threshold_o,
	output logic gate_high_o,
	output logic drain_sense_o,
	output logic output_good_o,
	output logic good_check_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] ramp = 4'h0;
	// Gate charges over several cycles so the ramp phase is visible
	always @(posedge clk_i) ramp <= gate_on_i ? ramp + {3'h0, ramp != 4'hf} : 4'h0;
	assign gate_threshold_o = ramp > 4'h2;
	assign gate_high_o = ramp > 4'h6;
	assign drain_sense_o = ~gate_high_o;
	assign output_good_o = gate_high_o;
	assign good_check_o = monitor_ok_i & gate_high_o;
endmodule

/* File: seq_timer.sv */
/*
 Tick-based down counter used for every sequencing delay.
 Assumes a one-cycle tick pulse from the shared timebase.
*/
module seq_timer #(
	parameter int W = 20
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	timer_if.tmr t
);
	logic [W-1:0] remaining;
	logic armed;

	// Start wins over stop so a restart in the clearing cycle is kept
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			remaining <= '0;
			armed <= 1'b0;
		end else if (t.start) begin
			remaining <= t.count;
			armed <= 1'b1;
		end else if (t.stop) begin
			armed <= 1'b0;
		end else if (tick_i && armed && remaining != '0) begin
			remaining <= remaining - 1'b1;
		end
	end

	assign t.expired = armed && remaining == '0;
endmodule

/* File: timer_if.sv */
/*
 Control carrier between the sequencer and one of its delay timers.
 Assumes both ends share one clock and one tick.
*/
interface timer_if #(parameter int W = 20);
	logic start;
	logic stop;
	logic [W-1:0] count;
	logic expired;
	modport ctrl(output start, output stop, output count, input expired);
	modport tmr(input start, input stop, input count, output expired);
endinterface
